// ---- inc/bridge_cfg_pkg.sv ----
// Register map, field layout and carrier types of the bridge configuration header block.
package bridge_cfg_pkg;

    // Byte addresses of the configuration words.
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_CLASS      = 8'h08;
    localparam logic [7:0] OFS_CACHE      = 8'h0C;
    localparam logic [7:0] OFS_BUS_NUM    = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h44;

    // Fixed values of the read-only fields.
    localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
    localparam logic [7:0] BASE_CLASS_BRIDGE    = 8'h06;
    localparam logic [7:0] SUB_CLASS_P2P        = 8'h04;
    localparam logic [7:0] PROG_IF_NONE         = 8'h00;
    localparam logic [7:0] HEADER_TYPE_BRIDGE   = 8'h01;

    // Values after reset of the writable fields.
    localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
    localparam logic [7:0] LATENCY_RESET    = 8'h00;
    localparam logic [7:0] BUS_NUM_RESET    = 8'h00;
    localparam logic [5:0] IRQ_MASK_RESET   = 6'h00;
    localparam logic [5:0] FLAGS_RESET      = 6'h00;

    // Index of each error flag inside the flag vector.
    localparam int FLG_MASTER_DPERR = 0;
    localparam int FLG_TABORT_SIG   = 1;
    localparam int FLG_TABORT_RX    = 2;
    localparam int FLG_MABORT_RX    = 3;
    localparam int FLG_SERR         = 4;
    localparam int FLG_PARITY       = 5;

    // Bit position of each error flag in the status word.
    localparam int POS_MASTER_DPERR = 24;
    localparam int POS_TABORT_SIG   = 27;
    localparam int POS_TABORT_RX    = 28;
    localparam int POS_MABORT_RX    = 29;
    localparam int POS_SERR         = 30;
    localparam int POS_PARITY       = 31;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [5:0] flag_type;

    typedef struct packed {
        logic addr_parity_err;
        logic data_parity_err;
        logic serr_asserted;
        logic master_abort_rx;
        logic target_abort_rx;
        logic target_abort_sig;
        logic master_data_parity_err;
    } bus_event_type;

    typedef struct packed {
        logic [7:0] cache_line_size;
        logic [7:0] latency_timer;
        logic [7:0] primary_bus;
        logic [7:0] secondary_bus;
    } cfg_out_type;

    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
        word_hit = (addr[7:2] == ofs[7:2]);
    endfunction

endpackage

// ---- core/sticky_flags.sv ----
// Bank of sticky event flags where a new event beats a clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module sticky_flags (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire bridge_cfg_pkg::flag_type set_vec,
    input  wire bridge_cfg_pkg::flag_type clr_vec,
    output var  bridge_cfg_pkg::flag_type flags
);
    import bridge_cfg_pkg::*;

    flag_type flags_r;
    flag_type flags_nxt;

    assign flags_nxt = (flags_r & ~clr_vec) | set_vec;
    assign flags     = flags_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- core/latency_counter.sv ----
// Master latency counter, loaded when the bridge starts a frame as master.
`timescale 1ns/1ps
`default_nettype none

module latency_counter (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       frame_start,
    input  wire logic       frame_active,
    input  wire logic [7:0] load_value,
    output logic      [7:0] count,
    output logic            expired
);
    import bridge_cfg_pkg::*;

    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic       expired_r;
    logic       expired_nxt;
    logic       counting;

    assign counting    = frame_active && (count_r != 8'h00);
    assign count_nxt   = frame_start ? load_value :
                         counting    ? count_r - 8'h01 : count_r;
    // A zero load expires one cycle after the load, as a load of one does, so the master gives up the bus after one data phase.
    assign expired_nxt = frame_active && !frame_start && (count_nxt == 8'h00);
    assign count       = count_r;
    assign expired     = expired_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r   <= LATENCY_RESET;
            expired_r <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            expired_r <= expired_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- core/bridge_config_header_regs.sv ----
// Primary status, class, cache line, latency, header type and bus number registers.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module bridge_config_header_regs #(
    parameter logic [7:0] REVISION_IDENT = 8'h3A // Arbitrary value.
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [7:0]                    awaddr,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic      [1:0]                    bresp,
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [7:0]                    araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic      [31:0]                   rdata,
    output logic      [1:0]                    rresp,
    input  wire bridge_cfg_pkg::bus_event_type bus_events,
    input  wire logic                          frame_start,
    input  wire logic                          frame_active,
    output var  bridge_cfg_pkg::cfg_out_type   cfg_out,
    output logic      [7:0]                    latency_count,
    output logic                               latency_expired,
    output logic                               irq
);
    import bridge_cfg_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Write channel holding registers; address and data may arrive in either order.
    logic        aw_held_r;
    logic        aw_held_nxt;
    logic [7:0]  aw_addr_r;
    logic        w_held_r;
    logic        w_held_nxt;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;

    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    cfg_out_type cfg_r;
    logic [5:0]  irq_mask_r;

    logic        aw_take;
    logic        w_take;
    logic        aw_have;
    logic        w_have;
    logic        do_write;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  wr_b0;
    logic [7:0]  wr_b1;
    logic        wr_mapped;
    logic        wsel_status;
    logic        wsel_cache;
    logic        wsel_bus;
    logic        wsel_irq_mask;

    logic        ar_take;
    logic        rd_mapped;
    logic        rd_irq_status;
    logic [31:0] rd_value;

    flag_type    status_flags;
    flag_type    irq_flags;
    flag_type    event_vec;
    flag_type    status_clr;
    flag_type    irq_clr;

    logic [31:0] status_word;
    logic [31:0] class_word;
    logic [31:0] cache_word;
    logic [31:0] bus_word;

    // Each bus event pulse feeds the flag of its own status bit; address and data parity errors share the parity flag.
    assign event_vec[FLG_PARITY]       = bus_events.addr_parity_err
                                       | bus_events.data_parity_err;
    assign event_vec[FLG_SERR]         = bus_events.serr_asserted;
    assign event_vec[FLG_MABORT_RX]    = bus_events.master_abort_rx;
    assign event_vec[FLG_TABORT_RX]    = bus_events.target_abort_rx;
    assign event_vec[FLG_TABORT_SIG]   = bus_events.target_abort_sig;
    assign event_vec[FLG_MASTER_DPERR] = bus_events.master_data_parity_err;

    // A write completes in the cycle in which both address and data are held or taken.
    assign awready  = !aw_held_r && !bvalid_r;
    assign wready   = !w_held_r && !bvalid_r;
    assign aw_take  = awvalid && awready;
    assign w_take   = wvalid && wready;
    assign aw_have  = aw_held_r || aw_take;
    assign w_have   = w_held_r || w_take;
    assign do_write = aw_have && w_have;

    assign wr_addr = aw_held_r ? aw_addr_r : awaddr;
    assign wr_data = w_held_r ? w_data_r : wdata;
    assign wr_strb = w_held_r ? w_strb_r : wstrb;
    assign wr_b0   = wr_data[7:0];
    assign wr_b1   = wr_data[15:8];

    assign wsel_status   = do_write && word_hit(wr_addr, OFS_STATUS);
    assign wsel_cache    = do_write && word_hit(wr_addr, OFS_CACHE);
    assign wsel_bus      = do_write && word_hit(wr_addr, OFS_BUS_NUM);
    assign wsel_irq_mask = do_write && word_hit(wr_addr, OFS_IRQ_MASK);
    // Writes to the read-only class word and to the read-clear interrupt status are accepted and dropped.
    assign wr_mapped = word_hit(wr_addr, OFS_STATUS) || word_hit(wr_addr, OFS_CLASS)
                    || word_hit(wr_addr, OFS_CACHE) || word_hit(wr_addr, OFS_BUS_NUM)
                    || word_hit(wr_addr, OFS_IRQ_STATUS) || word_hit(wr_addr, OFS_IRQ_MASK);

    assign aw_held_nxt = aw_have && !do_write;
    assign w_held_nxt  = w_have && !do_write;
    assign bvalid_nxt  = do_write || (bvalid_r && !bready);

    // Only the upper byte lane carries the error flags, so its strobe gates the clear.
    assign status_clr[FLG_PARITY]       = wsel_status && wr_strb[3] && wr_data[POS_PARITY];
    assign status_clr[FLG_SERR]         = wsel_status && wr_strb[3] && wr_data[POS_SERR];
    assign status_clr[FLG_MABORT_RX]    = wsel_status && wr_strb[3] && wr_data[POS_MABORT_RX];
    assign status_clr[FLG_TABORT_RX]    = wsel_status && wr_strb[3] && wr_data[POS_TABORT_RX];
    assign status_clr[FLG_TABORT_SIG]   = wsel_status && wr_strb[3] && wr_data[POS_TABORT_SIG];
    assign status_clr[FLG_MASTER_DPERR] = wsel_status && wr_strb[3]
                                        && wr_data[POS_MASTER_DPERR];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            bvalid_r  <= bvalid_nxt;
            if (aw_take) begin
                aw_addr_r <= awaddr;
            end
            if (w_take) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (do_write) begin
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r.cache_line_size <= CACHE_LINE_RESET;
            cfg_r.latency_timer   <= LATENCY_RESET;
            cfg_r.primary_bus     <= BUS_NUM_RESET;
            cfg_r.secondary_bus   <= BUS_NUM_RESET;
            irq_mask_r            <= IRQ_MASK_RESET;
        end else begin
            // Cache line size is stored as written; odd values are the programmer's fault.
            if (wsel_cache && wr_strb[0]) begin
                cfg_r.cache_line_size <= wr_b0;
            end
            if (wsel_cache && wr_strb[1]) begin
                cfg_r.latency_timer <= wr_b1;
            end
            if (wsel_bus && wr_strb[0]) begin
                cfg_r.primary_bus <= wr_b0;
            end
            if (wsel_bus && wr_strb[1]) begin
                cfg_r.secondary_bus <= wr_b1;
            end
            if (wsel_irq_mask && wr_strb[0]) begin
                irq_mask_r <= wr_b0[5:0];
            end
        end
    end

    sticky_flags u_status_flags (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .set_vec (event_vec),
        .clr_vec (status_clr),
        .flags   (status_flags)
    );

    // The interrupt copy of the flags is kept apart from the status copy.
    // A read of the interrupt status clears it, so software must read it once per service.
    assign irq_clr = rd_irq_status ? 6'h3F : 6'h00;

    sticky_flags u_irq_flags (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .set_vec (event_vec),
        .clr_vec (irq_clr),
        .flags   (irq_flags)
    );

    assign irq = |(irq_flags & irq_mask_r);

    // The counter reloads from the programmed timer at each frame start.
    latency_counter u_latency (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .frame_start  (frame_start),
        .frame_active (frame_active),
        .load_value   (cfg_r.latency_timer),
        .count        (latency_count),
        .expired      (latency_expired)
    );

    // Read data are registered, so the answer stands one cycle after the address is taken.
    assign status_word = {status_flags[FLG_PARITY],
                          status_flags[FLG_SERR],
                          status_flags[FLG_MABORT_RX],
                          status_flags[FLG_TABORT_RX],
                          status_flags[FLG_TABORT_SIG],
                          SELECT_TIMING_MEDIUM,
                          status_flags[FLG_MASTER_DPERR],
                          1'b1,
                          1'b0,
                          1'b1,
                          1'b1,
                          4'h0,
                          16'h0000};
    assign class_word = {BASE_CLASS_BRIDGE, SUB_CLASS_P2P, PROG_IF_NONE, REVISION_IDENT};
    assign cache_word = {8'h00, HEADER_TYPE_BRIDGE, cfg_r.latency_timer,
                         cfg_r.cache_line_size};
    assign bus_word   = {16'h0000, cfg_r.secondary_bus, cfg_r.primary_bus};

    assign arready       = !rvalid_r;
    assign ar_take       = arvalid && arready;
    assign rd_irq_status = ar_take && word_hit(araddr, OFS_IRQ_STATUS);
    assign rd_mapped     = word_hit(araddr, OFS_STATUS) || word_hit(araddr, OFS_CLASS)
                        || word_hit(araddr, OFS_CACHE) || word_hit(araddr, OFS_BUS_NUM)
                        || word_hit(araddr, OFS_IRQ_STATUS) || word_hit(araddr, OFS_IRQ_MASK);
    assign rd_value = word_hit(araddr, OFS_STATUS)     ? status_word :
                      word_hit(araddr, OFS_CLASS)      ? class_word :
                      word_hit(araddr, OFS_CACHE)      ? cache_word :
                      word_hit(araddr, OFS_BUS_NUM)    ? bus_word :
                      word_hit(araddr, OFS_IRQ_STATUS) ? {26'h0, irq_flags} :
                      word_hit(araddr, OFS_IRQ_MASK)   ? {26'h0, irq_mask_r} : 32'h0000_0000;
    assign rvalid_nxt = ar_take || (rvalid_r && !rready);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_value;
                rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign cfg_out = cfg_r;

    // The properties below guard the flags, the fixed fields, the cache line and bus number fields and the counter.
    a_parity_flag_set: assert property (
        (bus_events.addr_parity_err || bus_events.data_parity_err)
        |=> status_flags[FLG_PARITY])
        else $error("Parity error did not set the detected parity flag.");

    a_serr_flag_set: assert property (
        bus_events.serr_asserted |=> status_flags[FLG_SERR] && irq_flags[FLG_SERR])
        else $error("System error assertion did not set its flag.");

    a_mabort_flag_set: assert property (
        bus_events.master_abort_rx |=> status_flags[FLG_MABORT_RX])
        else $error("Master abort did not set its flag.");

    a_tabort_rx_set: assert property (
        bus_events.target_abort_rx |=> status_flags[FLG_TABORT_RX])
        else $error("Received target abort did not set its flag.");

    a_tabort_sig_set: assert property (
        bus_events.target_abort_sig |=> status_flags[FLG_TABORT_SIG])
        else $error("Signalled target abort did not set its flag.");

    a_master_dperr_cause: assert property (
        $rose(status_flags[FLG_MASTER_DPERR]) |-> $past(bus_events.master_data_parity_err))
        else $error("Master data parity flag rose without a cause.");

    a_status_fixed_bits: assert property (
        ar_take && word_hit(araddr, OFS_STATUS)
        |=> rvalid && rdata[26:25] == 2'b01 && rdata[23] && rdata[21] && rdata[20]
            && !rdata[22] && rdata[19:0] == 20'h00000)
        else $error("Status word fixed bits read wrong.");

    a_class_code_read: assert property (
        ar_take && word_hit(araddr, OFS_CLASS)
        |=> rdata[31:24] == 8'h06 && rdata[23:16] == 8'h04 && rdata[15:8] == 8'h00
            && rdata[7:0] == REVISION_IDENT)
        else $error("Class code or revision read wrong.");

    a_header_type_read: assert property (
        ar_take && word_hit(araddr, OFS_CACHE) |=> rdata[23:16] == 8'h01 && rdata[31:24] == 8'h00)
        else $error("Header type read wrong.");

    a_cache_line_write: assert property (
        wsel_cache && wr_strb[0] |=> cfg_out.cache_line_size == $past(wr_b0))
        else $error("Cache line size write not stored.");

    a_latency_load: assert property (
        frame_start |=> latency_count == $past(cfg_out.latency_timer))
        else $error("Latency counter not loaded at frame start.");

    a_bus_number_write: assert property (
        wsel_bus && wr_strb[0] && wr_strb[1]
        |=> cfg_out.primary_bus == $past(wr_b0) && cfg_out.secondary_bus == $past(wr_b1))
        else $error("Bus number write not stored.");

    a_w1c_clears_flag: assert property (
        wsel_status && wr_strb[3] && wr_data[POS_SERR] && !bus_events.serr_asserted
        |=> !status_flags[FLG_SERR])
        else $error("Write of one did not clear the system error flag.");

    a_w1c_zero_keeps: assert property (
        wsel_status && !wr_data[POS_PARITY] && status_flags[FLG_PARITY]
        |=> status_flags[FLG_PARITY])
        else $error("Write of zero changed the parity flag.");

endmodule

`default_nettype wire

// ---- verification/cfg_host_model.sv ----
// Host model that issues configuration reads and writes over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input  wire logic        sys_clk,
    input  wire logic        awready,
    input  wire logic        wready,
    input  wire logic        bvalid,
    input  wire logic [1:0]  bresp,
    input  wire logic        arready,
    input  wire logic        rvalid,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    output logic             awvalid,
    output logic      [7:0]  awaddr,
    output logic             wvalid,
    output logic      [31:0] wdata,
    output logic      [3:0]  wstrb,
    output logic             bready,
    output logic             arvalid,
    output logic      [7:0]  araddr,
    output logic             rready
);
    initial begin
        {awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready} = '0;
    end

    // Each valid drops only at the edge where its own ready was seen high.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge sys_clk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge sys_clk);
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge sys_clk);
            arvalid <= arvalid & ~arready;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_bridge_config_header_regs.sv ----
// Self-checking bench for the bridge configuration header registers.
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_config_header_regs;
    import bridge_cfg_pkg::*;
    localparam logic [7:0]  REV = 8'h5C; // Arbitrary value.
    localparam logic [31:0] ST_BASE = 32'h02B0_0000;
    localparam int          EV_POS [7] = '{24, 27, 28, 29, 30, 31, 31};
    logic          sys_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready, latency_expired, irq;
    logic [7:0]    awaddr, araddr, latency_count;
    logic [31:0]   wdata, rdata, rd_v;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, resp;
    bus_event_type bus_events = '0;
    logic          frame_start = 1'b0;
    logic          frame_active = 1'b0;
    cfg_out_type   cfg_out;
    int            error_cnt = 0;
    int            num_checks = 0;

    cfg_host_model host (
        .sys_clk (sys_clk),
        .awready (awready),
        .wready  (wready),
        .bvalid  (bvalid),
        .bresp   (bresp),
        .arready (arready),
        .rvalid  (rvalid),
        .rdata   (rdata),
        .rresp   (rresp),
        .awvalid (awvalid),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bready  (bready),
        .arvalid (arvalid),
        .araddr  (araddr),
        .rready  (rready)
    );
    bridge_config_header_regs #(.REVISION_IDENT(REV)) DUT (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .awvalid         (awvalid),
        .awready         (awready),
        .awaddr          (awaddr),
        .wvalid          (wvalid),
        .wready          (wready),
        .wdata           (wdata),
        .wstrb           (wstrb),
        .bvalid          (bvalid),
        .bready          (bready),
        .bresp           (bresp),
        .arvalid         (arvalid),
        .arready         (arready),
        .araddr          (araddr),
        .rvalid          (rvalid),
        .rready          (rready),
        .rdata           (rdata),
        .rresp           (rresp),
        .bus_events      (bus_events),
        .frame_start     (frame_start),
        .frame_active    (frame_active),
        .cfg_out         (cfg_out),
        .latency_count   (latency_count),
        .latency_expired (latency_expired),
        .irq             (irq)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        host.rd(a, rd_v, resp);
        chk(rd_v, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er = 2'h0);
        host.wr(a, d, s, resp);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic pulse_ev(input int i);
        @(posedge sys_clk);
        bus_events <= bus_event_type'(7'h01 << i);
        @(posedge sys_clk);
        bus_events <= '0;
    endtask

    task automatic t_reset();
        chk(cfg_out, 32'h0);
        rchk(OFS_STATUS, ST_BASE);
        rchk(OFS_CLASS, {8'h06, 8'h04, 8'h00, REV});
        rchk(OFS_CACHE, 32'h0001_0000);
        rchk(OFS_BUS_NUM, 32'h0);
    endtask

    // A strobe without the top lane must leave every flag standing.
    task automatic t_flags();
        for (int i = 0; i < 7; i++) begin
            pulse_ev(i);
            rchk(OFS_STATUS, ST_BASE | (32'h1 << EV_POS[i]));
            chk({31'h0, irq}, 32'h0);
            wchk(OFS_STATUS, 32'hFFFF_FFFF, 4'h7);
            wchk(OFS_STATUS, ~(32'h1 << EV_POS[i]), 4'hF);
            rchk(OFS_STATUS, ST_BASE | (32'h1 << EV_POS[i]));
            wchk(OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
            rchk(OFS_STATUS, ST_BASE);
        end
    endtask

    task automatic t_rw();
        wchk(OFS_CACHE, 32'hFFFF_2A10, 4'hF);
        rchk(OFS_CACHE, 32'h0001_2A10);
        wchk(OFS_BUS_NUM, 32'hFFFF_0503, 4'hF);
        rchk(OFS_BUS_NUM, 32'h0000_0503);
        chk(cfg_out, 32'h102A_0305);
        wchk(OFS_BUS_NUM, 32'h0000_0700, 4'h2);
        rchk(OFS_BUS_NUM, 32'h0000_0703);
        wchk(OFS_CLASS, 32'hFFFF_FFFF, 4'hF);
        rchk(OFS_CLASS, {8'h06, 8'h04, 8'h00, REV});
        wchk(8'h80, 32'h1, 4'hF, RESP_SLVERR);
        rchk(8'h80, 32'h0, RESP_SLVERR);
    endtask

    task automatic t_irq();
        host.rd(OFS_IRQ_STATUS, rd_v, resp);
        pulse_ev(4);
        #1;
        chk({31'h0, irq}, 32'h0);
        rchk(OFS_IRQ_STATUS, 32'h10);
        rchk(OFS_IRQ_STATUS, 32'h0);
        wchk(OFS_IRQ_MASK, 32'hFFFF_FF10, 4'h1);
        rchk(OFS_IRQ_MASK, 32'h10);
        pulse_ev(0);
        #1;
        chk({31'h0, irq}, 32'h0);
        pulse_ev(4);
        #1;
        chk({31'h0, irq}, 32'h1);
        rchk(OFS_IRQ_STATUS, 32'h11);
        #1;
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_latency();
        wchk(OFS_CACHE, 32'h0000_0404, 4'hF);
        @(posedge sys_clk);
        frame_start <= 1'b1;
        frame_active <= 1'b1;
        @(posedge sys_clk);
        frame_start <= 1'b0;
        #1;
        chk({24'h0, latency_count}, 32'h4);
        chk({31'h0, latency_expired}, 32'h0);
        repeat (4) @(posedge sys_clk);
        #1;
        chk({24'h0, latency_count}, 32'h0);
        @(posedge sys_clk);
        #1;
        chk({31'h0, latency_expired}, 32'h1);
        @(posedge sys_clk);
        frame_active <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_flags();
        t_rw();
        t_irq();
        t_latency();
        conclude();
    end

    // The full run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
